/* core/alu_regs.svh */
// Purpose: constants for the add/and ALU slice
// Assumes: 8-bit datapath
// Notes: included by bare name
`ifndef ALU_REGS_SVH
`define ALU_REGS_SVH

// --------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------
`define OFS_CTRL 4'h0
`define OFS_DST 4'h1
`define OFS_SRC 4'h2
`define OFS_RES 4'h3
`define OFS_FLAGS 4'h4
`define OFS_COND 4'h5

// --------------------------------------------------------------
// Field positions and codes
// --------------------------------------------------------------
`define FLAG_C 3
`define FLAG_Z 2
`define FLAG_S 1
`define FLAG_V 0
`define OP_ADD 2'h0
`define OP_ADC 2'h1
`define OP_AND 2'h2
`define CC_EQ 4'h6
`define CC_NE 4'he
`define RST_BYTE 8'h00
`define RST_FLAGS 4'h0

`endif

/* core/alu_pkg.sv */
// Purpose: types for the add/and ALU slice
// Assumes: alu_regs.svh holds the numbers
// Notes: the state codes are the only constant values here
package alu_pkg;

    // ----------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------
    typedef struct packed
    {
        logic c;
        logic z;
        logic s;
        logic v;
    } flags_t;

    typedef struct packed
    {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01
    } state_t;

endpackage

/* core/alu_core.sv */
// Purpose: 8-bit add, add-with-carry and AND slice with flags
// Assumes: decoder writes operands, then starts an operation
// Notes: result and flags update one cycle after the start write
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "alu_regs.svh"

module alu_core
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Result towards the register file
    output logic [7:0] dst_out,
    output logic dst_we,
    output logic cond_true
);

    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    // Nine-bit sum so the carry out of bit 7 survives
    function automatic logic [8:0] add9(input logic [7:0] a,
        input logic [7:0] b, input logic ci);
        add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    endfunction

    // Condition test against the flags
    function automatic logic cond_eval(input logic [3:0] cc,
        input alu_pkg::flags_t f);
        case (cc)
            `CC_EQ: cond_eval = f.z;
            `CC_NE: cond_eval = ~f.z;
            default: cond_eval = 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------
    // State
    // ----------------------------------------------------------
    // Bus request bundled into one carrier
    alu_pkg::bus_req_t req;
    alu_pkg::flags_t flags_r; // Live condition flags
    // Next-state values, settled combinationally
    alu_pkg::flags_t flags_nxt;
    alu_pkg::state_t state_r;
    alu_pkg::state_t state_nxt;
    logic [7:0] dst_r; // Destination operand
    logic [7:0] src_r; // Source operand, read by the ALU and the read mux, never written by the ALU
    logic [1:0] op_r; // Pending operation
    logic [3:0] cc_r; // Condition code under test
    logic [7:0] dst_nxt;
    logic [7:0] rdata_nxt;
    // Output flip-flops behind every port
    logic [7:0] rdata_r;
    logic we_r;
    logic cond_r;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // ----------------------------------------------------------
    // Decode
    // ----------------------------------------------------------
    // Strobes split per offset; exec blocks most of them later
    wire logic wr_ctrl = req.wr && (req.addr == `OFS_CTRL);
    wire logic wr_dst = req.wr && (req.addr == `OFS_DST);
    wire logic wr_src = req.wr && (req.addr == `OFS_SRC);
    wire logic wr_flags = req.wr && (req.addr == `OFS_FLAGS);
    wire logic wr_cond = req.wr && (req.addr == `OFS_COND);
    wire logic exec = (state_r == alu_pkg::ST_EXEC);

    // ----------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------
    // Carry-in only for the carry form
    wire logic cin = (op_r == `OP_ADC) ? flags_r.c : 1'b0;
    wire logic [8:0] sum = add9(dst_r, src_r, cin);
    wire logic [7:0] andv = dst_r & src_r;
    wire logic is_and = (op_r == `OP_AND);
    wire logic [7:0] res = is_and ? andv : sum[7:0];
    // Sign agreement of operands, then flip of the result
    wire logic ovf = (dst_r[7] == src_r[7]) && (res[7] != dst_r[7]);

    // Next flags, result and state
    always_comb
    begin
        flags_nxt = flags_r;
        dst_nxt = dst_r;
        state_nxt = alu_pkg::ST_IDLE;
        if (exec)
        begin
            // One execution cycle per start write
            dst_nxt = res;
            flags_nxt.z = (res == 8'h00);
            flags_nxt.s = res[7];
            if (is_and)
            begin
                // Carry kept for AND, overflow cleared
                flags_nxt.v = 1'b0;
            end
            else
            begin
                // Carry and overflow come from the adder
                flags_nxt.c = sum[8];
                flags_nxt.v = ovf;
            end
        end
        else
        begin
            // Software writes only while idle
            if (wr_dst)
                dst_nxt = req.wdata;
            if (wr_flags)
                flags_nxt = alu_pkg::flags_t'(req.wdata[3:0]);
            case (state_r)
                alu_pkg::ST_IDLE:
                    if (wr_ctrl)
                        state_nxt = alu_pkg::ST_EXEC;
                default: state_nxt = alu_pkg::ST_IDLE;
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        case (req.addr)
            `OFS_DST: rdata_nxt = dst_r;
            `OFS_SRC: rdata_nxt = src_r;
            `OFS_RES: rdata_nxt = dst_r;
            `OFS_FLAGS: rdata_nxt = {4'h0, flags_r};
            `OFS_COND: rdata_nxt = {3'h0, cond_r, cc_r};
            `OFS_CTRL: rdata_nxt = {6'h00, op_r};
            default: rdata_nxt = 8'h00;
        endcase
        // Holding the last value keeps rdata steady between reads
        if (!req.rd)
            rdata_nxt = rdata_r;
    end

    // ----------------------------------------------------------
    // Registers
    // ----------------------------------------------------------
    // Destination operand, flags and state
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dst_r <= `RST_BYTE;
            flags_r <= `RST_FLAGS;
            state_r <= alu_pkg::ST_IDLE;
        end
        else
        begin
            dst_r <= dst_nxt;
            flags_r <= flags_nxt;
            state_r <= state_nxt;
        end
    end

    // Source and control, never touched by execution
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            src_r <= `RST_BYTE;
            op_r <= `OP_ADD;
            cc_r <= `CC_EQ;
        end
        else
        begin
            // Refused while executing, so operands cannot tear
            if (wr_src && !exec)
                src_r <= req.wdata;
            if (wr_ctrl && !exec)
                op_r <= req.wdata[1:0];
            // Condition code may change at any time
            if (wr_cond)
                cc_r <= req.wdata[3:0];
        end
    end

    // Outputs straight from flip-flops
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_r <= `RST_BYTE;
            we_r <= 1'b0;
            cond_r <= 1'b0;
        end
        else
        begin
            rdata_r <= rdata_nxt;
            we_r <= exec;
            cond_r <= cond_eval(cc_r, flags_nxt);
        end
    end

    // Ports driven straight from the flip-flops above
    assign rdata = rdata_r;
    assign dst_out = dst_r;
    assign dst_we = we_r;
    assign cond_true = cond_r;

endmodule

/* sim/alu_core_props.sv */
// Purpose: port checks for alu_core
// Assumes: bound from the bench top
// Notes: shadows the condition code that software writes
`timescale 1ns/1ps
`include "alu_regs.svh"
module alu_core_props
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Result side
    input wire logic [7:0] dst_out,
    input wire logic dst_we,
    input wire logic cond_true
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic [3:0] cc_r; // Code in force
    wire start = wr && addr == `OFS_CTRL;
    wire zero = dst_out == 8'h00;
    // Codes are never refused, so a plain shadow is exact
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
            cc_r <= `CC_EQ;
        else if (wr && addr == `OFS_COND)
            cc_r <= wdata[3:0];
    property p_done; start |-> ##[2:3] dst_we; endproperty
    a_done: assert property (p_done) else $error("no result");
    property p_pulse; dst_we |=> !dst_we; endproperty
    a_pulse: assert property (p_pulse) else $error("long pulse");
    property p_cause;
        !$stable(dst_out) |-> dst_we || $past(wr && addr == `OFS_DST);
    endproperty
    a_cause: assert property (p_cause) else $error("stray dst");
    property p_why; $rose(dst_we) |-> $past(start, 2) || $past(start, 3);
    endproperty
    a_why: assert property (p_why) else $error("stray pulse");
    property p_eq; dst_we && cc_r == `CC_EQ |-> cond_true == zero;
    endproperty
    a_eq: assert property (p_eq) else $error("equal test");
    property p_ne; dst_we && cc_r == `CC_NE |-> cond_true == !zero;
    endproperty
    a_ne: assert property (p_ne) else $error("not-equal test");
    property p_res; rd && addr == `OFS_RES ##1 !dst_we |-> rdata == dst_out;
    endproperty
    a_res: assert property (p_res) else $error("result read");
    property p_hold; !$stable(rdata) |-> $past(rd); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unmap; rd && addr > `OFS_COND |=> rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("hole read");
    cover property (dst_we && zero);
    cover property (dst_we && cond_true);
    cover property (rd && addr == `OFS_RES);
endmodule

/* sim/regfile_model.sv */
// Purpose: register file side that takes results back
// Assumes: result is valid while the pulse is high
// Notes: the mirror is what software would see in the file
`timescale 1ns/1ps
module regfile_model
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Result from the slice
    input wire logic [7:0] dst_out,
    input wire logic dst_we,
    // Mirror of the destination
    output logic [7:0] mirror
);
    // Taken only on the pulse, so a late result goes unseen
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
            mirror <= 8'h00;
        else if (dst_we)
            mirror <= dst_out;
endmodule

/* sim/alu_core_test.sv */
// Purpose: table of add, carry-add and AND cases
// Assumes: one request per edge, inputs set after edges
// Notes: even rows test equal, odd rows not-equal
`timescale 1ns/1ps
`include "alu_regs.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
n_errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module alu_core_test;
    logic mclk = 0, rst_b = 0, wr = 0, rd = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, dst_out, mirror, q, r;
    logic dst_we, cond_true, cz;
    logic [8:0] s9;
    alu_pkg::flags_t ef;
    int n_errors = 0, samples_checked = 0;
    logic [7:0] td[8] = '{8'h12, 8'hff, 8'h7f, 8'h10,
        8'hff, 8'h12, 8'h80, 8'hf0};
    logic [7:0] ts[8] = '{8'h03, 8'h01, 8'h01, 8'h03,
        8'h00, 8'h03, 8'hff, 8'h20};
    logic [3:0] tf[8] = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h8, 4'h9, 4'h1, 4'h8};
    logic [1:0] to[8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    always #25 mclk = ~mclk;
    alu_core u_dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .dst_out(dst_out),
        .dst_we(dst_we), .cond_true(cond_true));
    regfile_model u_rf (.mclk(mclk), .rst_b(rst_b), .dst_out(dst_out),
        .dst_we(dst_we), .mirror(mirror));
    // One bus cycle, held until the next edge
    task bus(input logic w, input logic v, input logic [3:0] a,
        input logic [7:0] d);
        @(posedge mclk);
        wr <= w;
        rd <= v;
        addr <= a;
        wdata <= d;
    endtask
    task rd_t(input logic [3:0] a, output logic [7:0] d);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        @(negedge mclk);
        d = rdata;
    endtask
    task end_of_test;
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_errors++;
        end_of_test;
    end
    initial
    begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        rd_t(`OFS_DST, q); `CHK(q, `RST_BYTE)
        rd_t(`OFS_COND, q); `CHK(q, 8'h06)
        rd_t(4'h7, q); `CHK(q, 8'h00)
        for (int i = 0; i < 8; i++)
        begin
            // Expected result from two's-complement sums
            s9 = td[i] + ts[i] + ((to[i] == `OP_ADC) ? tf[i][3] : 1'b0);
            r = (to[i] == `OP_AND) ? (td[i] & ts[i]) : s9[7:0];
            ef.c = (to[i] == `OP_AND) ? tf[i][3] : s9[8];
            ef.z = r == 8'h00;
            ef.s = r[7];
            ef.v = to[i] != `OP_AND && td[i][7] == ts[i][7]
                && r[7] != td[i][7];
            cz = i[0] ? !ef.z : ef.z;
            bus(1'b1, 1'b0, `OFS_DST, td[i]);
            bus(1'b1, 1'b0, `OFS_SRC, ts[i]);
            bus(1'b1, 1'b0, `OFS_FLAGS, {4'h0, tf[i]});
            bus(1'b1, 1'b0, `OFS_COND, {4'h0, i[0] ? `CC_NE : `CC_EQ});
            bus(1'b1, 1'b0, `OFS_CTRL, {6'h00, to[i]});
            repeat (4) bus(1'b0, 1'b0, 4'h0, 8'h00);
            @(negedge mclk);
            `CHK(mirror, r)
            `CHK(cond_true, cz)
            rd_t(`OFS_RES, q); `CHK(q, r)
            rd_t(`OFS_FLAGS, q); `CHK(q, {4'h0, ef})
            rd_t(`OFS_SRC, q); `CHK(q, ts[i])
            rd_t(`OFS_COND, q); `CHK(q[4], cz)
        end
        end_of_test;
    end
endmodule
bind alu_core alu_core_props u_props (.mclk(mclk), .rst_b(rst_b),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .dst_out(dst_out), .dst_we(dst_we), .cond_true(cond_true));
